// ===== logic/inching_ctrl.sv
// two-input inching controller with apb register access
// assumes apb master on pclk; raw pins asynchronous, values from pclk logic
//
// How it works
// - raise and lower inputs each pick a source by type and index
// - both inputs are single bits; multi-valued sources become on/off first
// - value at/below minimum is off, at/above maximum on, hold between
// - raise on with lower off moves the output up
// - lower on with raise off moves the output down
// - both off or both on holds the output unchanged
// - output always stays within 0 to 100 percent
// - ramp mode changes output steadily while input on, pace from ramp time
// - notch mode changes output once per off-to-on edge by notch amount
// - per-direction mode selector: 0 ramp, 1 notch
// - enabled block starts at start value and holds until an input acts
`timescale 1ns/10ps
`include "inching_params.svh"

module inching_ctrl #(
    parameter int N_PIN = 4,
    parameter int N_VAL = 4,
    parameter int TICK_CYCLES = `TICK_US * (`CLK_HZ / 1000000)
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // signal sources
    input wire logic [N_PIN-1:0] src_pins,
    input wire logic [N_VAL*16-1:0] src_values,
    // output to downstream blocks
    output inching_pkg::level_type level_out
);

    localparam logic [22:0] FULL = {`LEVEL_MAX, {`FRAC_BITS{1'b0}}};

    // ****************************************
    // registers
    // ****************************************
    logic enable_r;
    inching_pkg::mode_type raise_mode_r;
    inching_pkg::mode_type lower_mode_r;
    logic [15:0] src_sel_r;
    logic [6:0] start_r;
    logic [15:0] raise_ramp_r;
    logic [15:0] lower_ramp_r;
    logic [6:0] raise_notch_r;
    logic [6:0] lower_notch_r;
    inching_pkg::thresh_type thr_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [31:0] rd_nxt;
    logic hit_nxt;
    logic wr_en;

    assign wr_en = psel & penable & pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_r <= 1'(`RST_CTRL >> `CTRL_ENABLE_BIT);
            raise_mode_r <= inching_pkg::mode_ramp;
            lower_mode_r <= inching_pkg::mode_ramp;
            src_sel_r <= `RST_SRC_SEL;
            start_r <= `RST_START;
            raise_ramp_r <= `RST_RAMP;
            lower_ramp_r <= `RST_RAMP;
            raise_notch_r <= `RST_NOTCH;
            lower_notch_r <= `RST_NOTCH;
            thr_r <= {`RST_THR_MIN, `RST_THR_MAX};
        end
        else if (wr_en)
        begin
            unique case (paddr)
                `OFF_CTRL:
                begin
                    enable_r <= pwdata[`CTRL_ENABLE_BIT];
                    raise_mode_r <= inching_pkg::mode_type'(pwdata[`CTRL_RAISE_MODE_BIT]);
                    lower_mode_r <= inching_pkg::mode_type'(pwdata[`CTRL_LOWER_MODE_BIT]);
                end
                `OFF_SRC_SEL: src_sel_r <= pwdata[15:0];
                `OFF_START: start_r <= (pwdata[6:0] > `LEVEL_MAX) ? `LEVEL_MAX : pwdata[6:0];
                `OFF_RAISE_RAMP: raise_ramp_r <= pwdata[15:0];
                `OFF_LOWER_RAMP: lower_ramp_r <= pwdata[15:0];
                `OFF_NOTCH:
                begin
                    raise_notch_r <= pwdata[6:0];
                    lower_notch_r <= pwdata[14:8];
                end
                `OFF_THRESH: thr_r <= {pwdata[15:0], pwdata[31:16]};
                default: ;
            endcase
        end
    end

    // ****************************************
    // read path, loaded in the setup phase
    // ****************************************
    logic raise_lvl;
    logic lower_lvl;
    inching_pkg::level_type value_r;

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        hit_nxt = 1'b1;
        unique case (paddr)
            `OFF_CTRL: rd_nxt = {29'h0, lower_mode_r, raise_mode_r, enable_r};
            `OFF_SRC_SEL: rd_nxt = {16'h0000, src_sel_r};
            `OFF_START: rd_nxt = {25'h0, start_r};
            `OFF_RAISE_RAMP: rd_nxt = {16'h0000, raise_ramp_r};
            `OFF_LOWER_RAMP: rd_nxt = {16'h0000, lower_ramp_r};
            `OFF_NOTCH: rd_nxt = {17'h0, lower_notch_r, 1'b0, raise_notch_r};
            `OFF_THRESH: rd_nxt = {thr_r.hi, thr_r.lo};
            `OFF_STATUS: rd_nxt = {22'h0, lower_lvl, raise_lvl, 1'b0, value_r.whole};
            default: hit_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr_r <= ~hit_nxt;
        end
    end

    // ****************************************
    // pin synchronisers and source conversion
    // ****************************************
    logic [N_PIN-1:0] pin_meta_r;
    logic [N_PIN-1:0] pin_sync_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end
        else
        begin
            pin_meta_r <= src_pins;
            pin_sync_r <= pin_meta_r;
        end
    end

    src_to_level #(.N_PIN(N_PIN), .N_VAL(N_VAL)) raise_src (
        .pclk(pclk),
        .presetn(presetn),
        .src_type(src_sel_r[3:0]),
        .src_index(src_sel_r[7:4]),
        .pins_sync(pin_sync_r),
        .values(src_values),
        .thr(thr_r),
        .level_r(raise_lvl)
    );

    src_to_level #(.N_PIN(N_PIN), .N_VAL(N_VAL)) lower_src (
        .pclk(pclk),
        .presetn(presetn),
        .src_type(src_sel_r[11:8]),
        .src_index(src_sel_r[15:12]),
        .pins_sync(pin_sync_r),
        .values(src_values),
        .thr(thr_r),
        .level_r(lower_lvl)
    );

    // ****************************************
    // update tick
    // ****************************************
    logic [31:0] tick_cnt_r;
    logic tick_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end
        else if (tick_cnt_r == 32'(TICK_CYCLES - 1))
        begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            tick_r <= 1'b0;
        end
    end

    // ****************************************
    // inching logic
    // ****************************************
    logic raise_prev_r;
    logic lower_prev_r;
    logic raise_act;
    logic lower_act;
    logic [22:0] raise_step;
    logic [22:0] lower_step;
    logic [23:0] up_sum;
    logic [22:0] cur;
    logic [22:0] delta_up;
    logic [22:0] delta_dn;
    logic [22:0] value_nxt;
    logic go_up;
    logic go_dn;

    assign raise_act = raise_lvl & ~lower_lvl;
    assign lower_act = lower_lvl & ~raise_lvl;
    assign cur = value_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raise_prev_r <= 1'b0;
            lower_prev_r <= 1'b0;
        end
        else
        begin
            raise_prev_r <= raise_lvl;
            lower_prev_r <= lower_lvl;
        end
    end

    // per-tick ramp increment is full scale over the ramp time in ticks
    assign raise_step = (raise_ramp_r == 16'h0000) ? FULL : FULL / {7'h0, raise_ramp_r};
    assign lower_step = (lower_ramp_r == 16'h0000) ? FULL : FULL / {7'h0, lower_ramp_r};
    always_comb
    begin
        go_up = 1'b0;
        go_dn = 1'b0;
        delta_up = raise_step;
        delta_dn = lower_step;
        if (raise_mode_r == inching_pkg::mode_notch)
        begin
            delta_up = {raise_notch_r, {`FRAC_BITS{1'b0}}};
            go_up = raise_act & raise_lvl & ~raise_prev_r;
        end
        else
            go_up = raise_act & tick_r;
        if (lower_mode_r == inching_pkg::mode_notch)
        begin
            delta_dn = {lower_notch_r, {`FRAC_BITS{1'b0}}};
            go_dn = lower_act & lower_lvl & ~lower_prev_r;
        end
        else
            go_dn = lower_act & tick_r;
        up_sum = {1'b0, cur} + {1'b0, delta_up};
        value_nxt = cur;
        if (go_up)
            value_nxt = (up_sum > {1'b0, FULL}) ? FULL : up_sum[22:0];
        else if (go_dn)
            value_nxt = (delta_dn > cur) ? 23'h0 : cur - delta_dn;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            value_r <= '0;
        else if (!enable_r)
            value_r <= {start_r, {`FRAC_BITS{1'b0}}};
        else
            value_r <= value_nxt;
    end
    assign level_out = value_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_range;
        value_r <= FULL;
    endproperty
    a_range: assert property (p_range) else $error("output above full scale");
    property p_hold;
        enable_r && (raise_lvl == lower_lvl) |=> value_r == $past(value_r);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved with equal inputs");
    property p_ramp_up;
        enable_r && raise_act && tick_r && raise_mode_r == inching_pkg::mode_ramp
            |=> value_r == (({1'b0, $past(cur)} + {1'b0, $past(raise_step)} > {1'b0, FULL})
                ? FULL : $past(cur) + $past(raise_step));
    endproperty
    a_ramp_up: assert property (p_ramp_up) else $error("ramp up step wrong");
    property p_ramp_dn;
        enable_r && lower_act && tick_r && lower_mode_r == inching_pkg::mode_ramp
            |=> value_r == (($past(lower_step) > $past(cur)) ? 23'h0
                : $past(cur) - $past(lower_step));
    endproperty
    a_ramp_dn: assert property (p_ramp_dn) else $error("ramp down step wrong");
    property p_notch_up;
        enable_r && raise_act && !raise_prev_r && raise_mode_r == inching_pkg::mode_notch
            |=> value_r.whole == ((8'($past(value_r.whole)) + 8'($past(raise_notch_r)) > 8'h64)
                ? `LEVEL_MAX : 7'($past(value_r.whole) + $past(raise_notch_r)));
    endproperty
    a_notch_up: assert property (p_notch_up) else $error("notch up wrong");
    property p_notch_once;
        enable_r && raise_mode_r == inching_pkg::mode_notch && raise_act && raise_prev_r
            && lower_mode_r == inching_pkg::mode_notch |=> value_r == $past(value_r);
    endproperty
    a_notch_once: assert property (p_notch_once) else $error("notch repeated");
    property p_start;
        !enable_r |=> value_r.whole == $past(start_r) && value_r.frac == '0;
    endproperty
    a_start: assert property (p_start) else $error("start value not held");
    property p_no_tick_ramp;
        enable_r && !tick_r && raise_mode_r == inching_pkg::mode_ramp
            && lower_mode_r == inching_pkg::mode_ramp |=> value_r == $past(value_r);
    endproperty
    a_no_tick_ramp: assert property (p_no_tick_ramp) else $error("ramp moved off tick");
    c_reach_full: cover property (enable_r && raise_act ##1 value_r == FULL);
    c_reach_zero: cover property (enable_r && lower_act ##1 value_r == '0);
    c_notch_dn: cover property (lower_mode_r == inching_pkg::mode_notch && go_dn);
    c_both_on: cover property (enable_r && raise_lvl && lower_lvl);

endmodule

// ===== logic/inching_params.svh
// constants for the two-input inching controller
// assumes a 20 MHz pclk and 32-bit apb word addressing
`ifndef INCHING_PARAMS_SVH
`define INCHING_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFF_CTRL 12'h000
`define OFF_SRC_SEL 12'h004
`define OFF_START 12'h008
`define OFF_RAISE_RAMP 12'h00c
`define OFF_LOWER_RAMP 12'h010
`define OFF_NOTCH 12'h014
`define OFF_THRESH 12'h018
`define OFF_STATUS 12'h01c

// ****************************************
// field positions
// ****************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_RAISE_MODE_BIT 1
`define CTRL_LOWER_MODE_BIT 2
`define STATUS_RAISE_LVL_BIT 8
`define STATUS_LOWER_LVL_BIT 9

// ****************************************
// reset values
// ****************************************
`define RST_CTRL 3'h0
`define RST_SRC_SEL 16'h0000
`define RST_START 7'h00
`define RST_RAMP 16'h0000
`define RST_NOTCH 7'h0a
`define RST_THR_MIN 16'h0000
`define RST_THR_MAX 16'hffff

// ****************************************
// range and timing
// ****************************************
`define LEVEL_MAX 7'h64
`define FRAC_BITS 16
`define CLK_HZ 20000000
`define TICK_US 1000

`endif

// ===== logic/inching_pkg.sv
// types shared by the inching controller files
// assumes inching_params.svh defines the fraction width
`include "inching_params.svh"

package inching_pkg;

    typedef enum logic [3:0] {src_unused, src_pin, src_value} src_kind_type;

    typedef enum logic {mode_ramp, mode_notch} mode_type;

    typedef struct packed {
        logic [6:0] whole;
        logic [`FRAC_BITS-1:0] frac;
    } level_type;

    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
    } thresh_type;

endpackage

// ===== logic/src_to_level.sv
// source selector with on/off hysteresis for one control input
// assumes pins are already synchronised to pclk
`timescale 1ns/10ps
`include "inching_params.svh"

module src_to_level #(
    parameter int N_PIN = 4,
    parameter int N_VAL = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // selection
    input wire logic [3:0] src_type,
    input wire logic [3:0] src_index,
    // candidate sources
    input wire logic [N_PIN-1:0] pins_sync,
    input wire logic [N_VAL*16-1:0] values,
    input wire inching_pkg::thresh_type thr,
    // on/off result
    output logic level_r
);

    logic level_nxt;
    logic [15:0] val_sel;
    int idx;

    // ****************************************
    // selection and hysteresis
    // ****************************************
    always_comb
    begin
        idx = int'(src_index);
        val_sel = 16'h0000;
        level_nxt = 1'b0;
        if (src_type == inching_pkg::src_pin)
        begin
            if (idx >= 1 && idx <= N_PIN)
                level_nxt = pins_sync[idx-1];
        end
        else if (src_type == inching_pkg::src_value)
        begin
            level_nxt = level_r;
            if (idx >= 1 && idx <= N_VAL)
            begin
                val_sel = values[(idx-1)*16 +: 16];
                if (val_sel <= thr.lo)
                    level_nxt = 1'b0;
                else if (val_sel >= thr.hi)
                    level_nxt = 1'b1;
            end
            else
                level_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            level_r <= 1'b0;
        else
            level_r <= level_nxt;
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_off_below;
        (src_type == inching_pkg::src_value) && idx >= 1 && idx <= N_VAL
            && val_sel <= thr.lo |=> !level_r;
    endproperty
    a_off_below: assert property (p_off_below) else $error("level not off at minimum");

    property p_hyst_hold;
        (src_type == inching_pkg::src_value) && idx >= 1 && idx <= N_VAL
            && val_sel > thr.lo && val_sel < thr.hi |=> level_r == $past(level_r);
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("level moved inside band");

    property p_unused_off;
        src_type == inching_pkg::src_unused |=> !level_r;
    endproperty
    a_unused_off: assert property (p_unused_off) else $error("unused source gives on");

endmodule

// ===== test/dual_input_inching_control_bench.sv
// self-checking bench for the two-input inching controller
// assumes inching_ctrl with apb access and a source model on its inputs
`timescale 1ns/10ps
`include "inching_params.svh"

module dual_input_inching_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] pin_req = 4'h0;
    logic [63:0] val_req = 64'h0;
    logic [3:0] src_pins;
    logic [63:0] src_values;
    inching_pkg::level_type level_out;
    inching_pkg::level_type lvl_prev = '0;
    logic [32:0] apb_q[$];
    logic [22:0] lvl_q[$];
    logic [32:0] e_apb;
    logic [31:0] x;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 5;
    int lvl;
    int k;

    always #25 pclk = ~pclk;

    inching_ctrl #(.N_PIN(4), .N_VAL(4), .TICK_CYCLES(10)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_pins(src_pins),
        .src_values(src_values), .level_out(level_out));

    source_model sm (.pclk(pclk), .pin_req(pin_req), .val_req(val_req),
        .src_pins(src_pins), .src_values(src_values));

    // ****************************************
    // shared tasks
    // ****************************************
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             input logic [32:0] exp);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        apb_q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                fail_count++;
                results();
            end
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {1'b0, 32'h0});
    endtask

    task rd(input logic [11:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {1'b0, d});
    endtask

    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task set_val(input logic [15:0] v);
        @(posedge pclk);
        val_req[15:0] <= v;
    endtask

    task set_pin(input logic [3:0] v);
        @(posedge pclk);
        pin_req <= v;
    endtask

    task wait_lvl;
        int n;
        n = 0;
        while (lvl_q.size() != 0)
        begin
            n++;
            if (n > 300)
            begin
                fail_count++;
                results();
            end
            @(posedge pclk);
        end
    endtask

    // ****************************************
    // output watchers
    // ****************************************
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            e_apb = apb_q.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, e_apb[32]});
            check("prdata", prdata, e_apb[31:0]);
        end
    end

    always @(posedge pclk)
    begin
        if (presetn && level_out !== lvl_prev)
            check("level_out", {9'h0, level_out}, {9'h0, lvl_q.pop_front()});
        lvl_prev <= level_out;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFF_CTRL, 32'h0);
        rd(`OFF_SRC_SEL, 32'h0);
        rd(`OFF_START, 32'h0);
        rd(`OFF_RAISE_RAMP, 32'h0);
        rd(`OFF_LOWER_RAMP, 32'h0);
        rd(`OFF_NOTCH, 32'h0a0a);
        rd(`OFF_THRESH, 32'hffff0000);
        apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h020, 32'h5, {1'b1, 32'h0});
        wr(`OFF_STATUS, 32'h3ff);
        rd(`OFF_STATUS, 32'h0);
        // start value tracks while disabled, clamped to the range
        lvl_q.push_back(23'(50 << 16));
        wr(`OFF_START, 32'h32);
        wait_lvl();
        lvl_q.push_back(23'(100 << 16));
        wr(`OFF_START, 32'h75);
        wait_lvl();
        rd(`OFF_START, 32'h64);
        lvl_q.push_back(23'(40 << 16));
        wr(`OFF_START, 32'h28);
        wait_lvl();
        wr(`OFF_SRC_SEL, 32'h2112);
        wr(`OFF_THRESH, 32'h80001000);
        wr(`OFF_NOTCH, 32'h191e);
        wr(`OFF_RAISE_RAMP, 32'h4);
        wr(`OFF_LOWER_RAMP, 32'h3);
        wr(`OFF_CTRL, 32'h7);
        rd(`OFF_STATUS, 32'h28);
        // notch raise from a value source with hysteresis
        lvl_q.push_back(23'(70 << 16));
        set_val(16'h9000);
        wait_lvl();
        for (k = 0; k < 4; k++)
        begin
            x = $random(seed);
            set_val(16'h1001 + 16'(x[15:0] % 16'h6ffe));
            tick(4);
            rd(`OFF_STATUS, 32'h146);
        end
        set_val(16'h1000);
        tick(4);
        rd(`OFF_STATUS, 32'h046);
        lvl_q.push_back(23'(100 << 16));
        set_val(16'h8000);
        wait_lvl();
        set_val(16'h0000);
        tick(4);
        set_val(16'hffff);
        tick(6);
        rd(`OFF_STATUS, 32'h164);
        set_val(16'h0000);
        // notch lower from pin 2, then both on
        lvl_q.push_back(23'(75 << 16));
        set_pin(4'h2);
        wait_lvl();
        set_val(16'h9000);
        tick(6);
        rd(`OFF_STATUS, 32'h34b);
        set_pin(4'h0);
        tick(6);
        rd(`OFF_STATUS, 32'h14b);
        set_val(16'h0000);
        tick(4);
        // ramp both directions
        wr(`OFF_CTRL, 32'h1);
        lvl = 75 << 16;
        while (lvl > 0)
        begin
            lvl = lvl - (100 << 16) / 3;
            if (lvl < 0)
                lvl = 0;
            lvl_q.push_back(lvl[22:0]);
        end
        set_pin(4'h2);
        wait_lvl();
        tick(20);
        rd(`OFF_STATUS, 32'h200);
        set_pin(4'h0);
        tick(6);
        for (k = 1; k <= 4; k++)
            lvl_q.push_back(23'(k * ((100 << 16) / 4)));
        set_val(16'h9000);
        wait_lvl();
        tick(20);
        rd(`OFF_STATUS, 32'h164);
        set_val(16'h0000);
        tick(6);
        lvl_q.push_back(23'(40 << 16));
        wr(`OFF_CTRL, 32'h0);
        wait_lvl();
        check("pending level notes", lvl_q.size(), 32'h0);
        results();
    end
endmodule

// ===== test/source_model.sv
// far-side model: the selectable signal sources feeding the controller
// assumes the bench drives pin_req and val_req just after rising edges
`timescale 1ns/10ps

module source_model (
    // clock
    input wire logic pclk,
    // requests from the bench
    input wire logic [3:0] pin_req,
    input wire logic [63:0] val_req,
    // sources seen by the controller
    output logic [3:0] src_pins,
    output logic [63:0] src_values
);
    initial
    begin
        src_pins = 4'h0;
        src_values = 64'h0;
    end
    // value sources are pclk logic
    always @(posedge pclk)
        src_values <= val_req;
    // raw pins also move on the rising edge; the controller synchronises them
    always @(posedge pclk)
        src_pins <= pin_req;
endmodule
